// [logic/dma_chan_consts.svh]
// Register offsets, field positions and reset values of the DMA channel.
// Assumes byte addresses on an 8-bit register address port.
`ifndef DMA_CHAN_CONSTS_SVH
`define DMA_CHAN_CONSTS_SVH

`define DMA_CTRL_OFFSET 8'h20
`define DMA_MAXLEN_OFFSET 8'h24

`define CTRL_IRQ_NUM_HI 31
`define CTRL_IRQ_NUM_LO 26
`define CTRL_ERR_END 23
`define CTRL_TRUNC 22
`define CTRL_EEP_CODE_EN 21
`define CTRL_TRUNC_CODE_EN 20
`define CTRL_RX_IRQ_FLAG 19
`define CTRL_TX_IRQ_FLAG 18
`define CTRL_STRIP_PID 15
`define CTRL_STRIP_ADDR 14
`define CTRL_SEP_ADDR_EN 13
`define CTRL_NO_SPILL 12
`define CTRL_RX_DESC_AVAIL 11
`define CTRL_RX_ACTIVE 10
`define CTRL_ABORT 9
`define CTRL_RX_BUS_ERR 8
`define CTRL_TX_BUS_ERR 7
`define CTRL_PKT_RX 6
`define CTRL_PKT_TX 5
`define CTRL_BUS_ERR_IRQ_EN 4
`define CTRL_RX_IRQ_EN 3
`define CTRL_TX_IRQ_EN 2
`define CTRL_RX_EN 1
`define CTRL_TX_EN 0

`define MAXLEN_HI 24
`define MAXLEN_LO 2

`define MAXLEN_RESET 23'h00_0000
`define IRQ_NUM_RESET 6'h00
`define RDATA_RESET 32'h0000_0000

`endif

// [logic/dma_chan_pkg.sv]
// Types shared by the DMA channel control block and its byte stripper.
// Assumes the constants header is compiled alongside.
`default_nettype none
package dma_chan_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic eep;
  } rx_byte_type;

  typedef struct packed {
    logic strip_addr;
    logic strip_pid;
    logic [22:0] max_len;
  } strip_cfg_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RECV = 2'b01,
    RX_DISCARD = 2'b10
  } rx_state_type;

endpackage

`default_nettype wire

// [logic/byte_stripper.sv]
// Drops leading address/protocol-id bytes and truncates over-long packets.
// Assumes one byte per valid cycle, same clock, no back-pressure downstream.
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_consts.svh"

module byte_stripper #(
  parameter int MAXLEN_WIDTH = 23
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dma_chan_pkg::strip_cfg_type i_cfg,
  input wire logic i_in_valid,
  input wire dma_chan_pkg::rx_byte_type i_in,
  output logic o_out_valid,
  output var dma_chan_pkg::rx_byte_type o_out,
  output logic o_end,
  output logic o_end_trunc,
  output logic o_end_eep
);

  if (MAXLEN_WIDTH < 1 || MAXLEN_WIDTH > 23)
  begin : g_bad_width
    $error("byte_stripper: MAXLEN_WIDTH must be 1 to 23");
  end

  logic [1:0] byte_idx;
  logic [MAXLEN_WIDTH+1:0] count;
  logic trunc_seen;
  logic drop;
  logic over;
  logic [MAXLEN_WIDTH+1:0] limit;

  // Length is in 32-bit words, so the byte limit is four times it
  // words to bytes
  assign limit = {i_cfg.max_len[MAXLEN_WIDTH-1:0], 2'b00};

  assign drop = (byte_idx == 2'd0 && (i_cfg.strip_addr || i_cfg.strip_pid))
    || (byte_idx == 2'd1 && i_cfg.strip_pid);
  assign over = !drop && (count >= limit);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || (i_in_valid && i_in.last))
    begin
      byte_idx <= 2'd0;
      count <= '0;
      trunc_seen <= 1'b0;
    end
    else if (i_in_valid)
    begin
      if (byte_idx != 2'd2)
        byte_idx <= byte_idx + 2'd1;
      if (!drop && !over)
        count <= count + 1'b1;
      if (over)
        trunc_seen <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_out_valid <= 1'b0;
      o_out <= '0;
      o_end <= 1'b0;
      o_end_trunc <= 1'b0;
      o_end_eep <= 1'b0;
    end
    else
    begin
      o_out_valid <= i_in_valid && !drop && !over;
      o_out <= i_in;
      o_end <= i_in_valid && i_in.last;
      o_end_trunc <= i_in_valid && i_in.last && (trunc_seen || over);
      o_end_eep <= i_in_valid && i_in.eep;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_STRIP_FIRST: assert property (
    i_in_valid && byte_idx == 2'd0 && (i_cfg.strip_addr || i_cfg.strip_pid)
    |=> !o_out_valid)
    else $error("First byte delivered although stripping is on");

  AST_STRIP_PID: assert property (
    i_in_valid && byte_idx == 2'd1 && i_cfg.strip_pid |=> !o_out_valid)
    else $error("Second byte delivered although pid stripping is on");

  AST_MAX_LEN: assert property (
    o_out_valid |-> count <= limit)
    else $error("More bytes delivered than the word limit allows");

endmodule

`default_nettype wire

// [logic/dma_chan_ctrl.sv]
// Control and status of one DMA channel of the router's bus-attached port.
// Assumes packet path, descriptor fetch and bus errors share i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "dma_chan_consts.svh"

module dma_chan_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_rx_valid,
  input wire dma_chan_pkg::rx_byte_type i_rx_byte,
  output logic o_rx_ready,
  input wire logic i_rx_desc_active,
  input wire logic i_rx_desc_disabled,
  input wire logic i_rx_desc_irq_en,
  input wire logic i_rx_bus_err,
  output logic o_wr_valid,
  output var dma_chan_pkg::rx_byte_type o_wr_byte,
  output logic o_wr_end,
  output logic o_wr_trunc,
  output logic o_wr_eep,
  output logic o_tx_fetch,
  output logic o_tx_abort,
  input wire logic i_tx_done,
  input wire logic i_tx_desc_disabled,
  input wire logic i_tx_desc_irq_en,
  input wire logic i_tx_bus_err,
  output logic o_irq,
  output logic o_dist_int_valid,
  output logic [5:0] o_dist_int_num,
  output logic o_sep_addr_en
);

  // Hardware set wins over a software clear in the same cycle
  function automatic logic w1c(input logic flag, input logic set,
                               input logic clr);
    w1c = set | (flag & ~clr);
  endfunction

  logic [5:0] irq_num;
  logic err_end_flag;
  logic trunc_flag;
  logic eep_code_en;
  logic trunc_code_en;
  logic rx_irq_flag;
  logic tx_irq_flag;
  logic strip_pid;
  logic strip_addr;
  logic no_spill;
  logic rx_desc_avail;
  logic rx_bus_err_flag;
  logic tx_bus_err_flag;
  logic pkt_rx_flag;
  logic pkt_tx_flag;
  logic bus_err_irq_en;
  logic rx_irq_en;
  logic tx_irq_en;
  logic rx_en;
  logic tx_en;
  logic tx_busy;
  logic [22:0] max_len;
  dma_chan_pkg::rx_state_type rx_state;
  dma_chan_pkg::rx_state_type next_rx_state;
  dma_chan_pkg::strip_cfg_type strip_cfg;
  logic wr_ctrl;
  logic wr_len;
  logic abort_wr;
  logic accept;
  logic desc_ok;
  logic feed;
  logic rx_irq_ev;
  logic tx_irq_ev;
  logic err_irq_ev;
  logic [31:0] ctrl_word;

  assign wr_ctrl = i_wr && (i_addr == `DMA_CTRL_OFFSET);
  assign wr_len = i_wr && (i_addr == `DMA_MAXLEN_OFFSET);
  assign abort_wr = wr_ctrl && i_wdata[`CTRL_ABORT];

  // Plain control bits
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_num <= `IRQ_NUM_RESET;
      eep_code_en <= 1'b0;
      trunc_code_en <= 1'b0;
      strip_pid <= 1'b0;
      strip_addr <= 1'b0;
      o_sep_addr_en <= 1'b0;
      no_spill <= 1'b0;
      bus_err_irq_en <= 1'b0;
      rx_irq_en <= 1'b0;
      tx_irq_en <= 1'b0;
      rx_en <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      irq_num <= i_wdata[`CTRL_IRQ_NUM_HI:`CTRL_IRQ_NUM_LO];
      eep_code_en <= i_wdata[`CTRL_EEP_CODE_EN];
      trunc_code_en <= i_wdata[`CTRL_TRUNC_CODE_EN];
      strip_pid <= i_wdata[`CTRL_STRIP_PID];
      strip_addr <= i_wdata[`CTRL_STRIP_ADDR];
      o_sep_addr_en <= i_wdata[`CTRL_SEP_ADDR_EN];
      no_spill <= i_wdata[`CTRL_NO_SPILL];
      bus_err_irq_en <= i_wdata[`CTRL_BUS_ERR_IRQ_EN];
      rx_irq_en <= i_wdata[`CTRL_RX_IRQ_EN];
      tx_irq_en <= i_wdata[`CTRL_TX_IRQ_EN];
      rx_en <= i_wdata[`CTRL_RX_EN];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      max_len <= `MAXLEN_RESET;
    else if (wr_len)
      max_len <= i_wdata[`MAXLEN_HI:`MAXLEN_LO];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rx_desc_avail <= 1'b0;
    else if (wr_ctrl)
      rx_desc_avail <= i_wdata[`CTRL_RX_DESC_AVAIL] ||
        (rx_desc_avail && !i_rx_desc_disabled);
    else if (i_rx_desc_disabled)
      rx_desc_avail <= 1'b0;
  end

  // Receive path
  assign accept = i_rx_valid && o_rx_ready;
  assign desc_ok = i_rx_desc_active && rx_desc_avail;
  assign feed = accept && (rx_state == dma_chan_pkg::RX_RECV ||
    (rx_state == dma_chan_pkg::RX_IDLE && rx_en && desc_ok));

  always_comb
  begin
    next_rx_state = rx_state;
    case (rx_state)
      dma_chan_pkg::RX_IDLE:
        if (accept && !i_rx_byte.last)
          next_rx_state = (rx_en && desc_ok) ? dma_chan_pkg::RX_RECV
                                             : dma_chan_pkg::RX_DISCARD;
      dma_chan_pkg::RX_RECV,
      dma_chan_pkg::RX_DISCARD:
        if (accept && i_rx_byte.last)
          next_rx_state = dma_chan_pkg::RX_IDLE;
      default:
        next_rx_state = dma_chan_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rx_state <= dma_chan_pkg::RX_IDLE;
    else
      rx_state <= next_rx_state;
  end

  // Ready is registered, so a change of enable takes one cycle to bite
  // stall with no-spill
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rx_ready <= 1'b0;
    else if (next_rx_state != dma_chan_pkg::RX_IDLE)
      o_rx_ready <= 1'b1;
    else
      o_rx_ready <= rx_en && (desc_ok || !no_spill);
  end

  assign strip_cfg = '{strip_addr: strip_addr, strip_pid: strip_pid,
                       max_len: max_len};

  byte_stripper #(
    .MAXLEN_WIDTH(23)
  ) u_stripper (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_cfg(strip_cfg),
    .i_in_valid(feed),
    .i_in(i_rx_byte),
    .o_out_valid(o_wr_valid),
    .o_out(o_wr_byte),
    .o_end(o_wr_end),
    .o_end_trunc(o_wr_trunc),
    .o_end_eep(o_wr_eep)
  );

  // Transmit control
  // fetch while enabled
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_en <= 1'b0;
      tx_busy <= 1'b0;
      o_tx_fetch <= 1'b0;
      o_tx_abort <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        tx_en <= i_wdata[`CTRL_TX_EN] && !i_wdata[`CTRL_ABORT];
      else if (i_tx_desc_disabled)
        tx_en <= 1'b0;
      o_tx_fetch <= tx_en && !tx_busy && !abort_wr;
      if (tx_en && !tx_busy && !abort_wr)
        tx_busy <= 1'b1;
      else if (i_tx_done || i_tx_desc_disabled)
        tx_busy <= 1'b0;
      o_tx_abort <= abort_wr && tx_busy;
    end
  end

  // Events
  // receive packet interrupt
  assign rx_irq_ev = o_wr_end && rx_irq_en && i_rx_desc_irq_en;
  assign tx_irq_ev = i_tx_done && tx_irq_en && i_tx_desc_irq_en;
  assign err_irq_ev = (i_rx_bus_err || i_tx_bus_err) && bus_err_irq_en;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
      o_dist_int_valid <= 1'b0;
      o_dist_int_num <= `IRQ_NUM_RESET;
    end
    else
    begin
      o_irq <= rx_irq_ev || tx_irq_ev || err_irq_ev;
      o_dist_int_valid <= o_wr_end && ((o_wr_trunc && trunc_code_en) ||
        (o_wr_eep && eep_code_en));
      o_dist_int_num <= irq_num;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      err_end_flag <= 1'b0;
      trunc_flag <= 1'b0;
      rx_irq_flag <= 1'b0;
      tx_irq_flag <= 1'b0;
      rx_bus_err_flag <= 1'b0;
      tx_bus_err_flag <= 1'b0;
      pkt_rx_flag <= 1'b0;
      pkt_tx_flag <= 1'b0;
    end
    else
    begin
      err_end_flag <= w1c(err_end_flag, o_wr_end && o_wr_eep,
        wr_ctrl && i_wdata[`CTRL_ERR_END]);
      trunc_flag <= w1c(trunc_flag, o_wr_end && o_wr_trunc,
        wr_ctrl && i_wdata[`CTRL_TRUNC]);
      rx_irq_flag <= w1c(rx_irq_flag, rx_irq_ev,
        wr_ctrl && i_wdata[`CTRL_RX_IRQ_FLAG]);
      tx_irq_flag <= w1c(tx_irq_flag, tx_irq_ev,
        wr_ctrl && i_wdata[`CTRL_TX_IRQ_FLAG]);
      rx_bus_err_flag <= w1c(rx_bus_err_flag, i_rx_bus_err && bus_err_irq_en,
        wr_ctrl && i_wdata[`CTRL_RX_BUS_ERR]);
      tx_bus_err_flag <= w1c(tx_bus_err_flag, i_tx_bus_err,
        wr_ctrl && i_wdata[`CTRL_TX_BUS_ERR]);
      pkt_rx_flag <= w1c(pkt_rx_flag, o_wr_end,
        wr_ctrl && i_wdata[`CTRL_PKT_RX]);
      pkt_tx_flag <= w1c(pkt_tx_flag, i_tx_done,
        wr_ctrl && i_wdata[`CTRL_PKT_TX]);
    end
  end

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[`CTRL_IRQ_NUM_HI:`CTRL_IRQ_NUM_LO] = irq_num;
    ctrl_word[`CTRL_ERR_END] = err_end_flag;
    ctrl_word[`CTRL_TRUNC] = trunc_flag;
    ctrl_word[`CTRL_EEP_CODE_EN] = eep_code_en;
    ctrl_word[`CTRL_TRUNC_CODE_EN] = trunc_code_en;
    ctrl_word[`CTRL_RX_IRQ_FLAG] = rx_irq_flag;
    ctrl_word[`CTRL_TX_IRQ_FLAG] = tx_irq_flag;
    ctrl_word[`CTRL_STRIP_PID] = strip_pid;
    ctrl_word[`CTRL_STRIP_ADDR] = strip_addr;
    ctrl_word[`CTRL_SEP_ADDR_EN] = o_sep_addr_en;
    ctrl_word[`CTRL_NO_SPILL] = no_spill;
    ctrl_word[`CTRL_RX_DESC_AVAIL] = rx_desc_avail;
    ctrl_word[`CTRL_RX_ACTIVE] = (rx_state == dma_chan_pkg::RX_RECV);
    ctrl_word[`CTRL_RX_BUS_ERR] = rx_bus_err_flag;
    ctrl_word[`CTRL_TX_BUS_ERR] = tx_bus_err_flag;
    ctrl_word[`CTRL_PKT_RX] = pkt_rx_flag;
    ctrl_word[`CTRL_PKT_TX] = pkt_tx_flag;
    ctrl_word[`CTRL_BUS_ERR_IRQ_EN] = bus_err_irq_en;
    ctrl_word[`CTRL_RX_IRQ_EN] = rx_irq_en;
    ctrl_word[`CTRL_TX_IRQ_EN] = tx_irq_en;
    ctrl_word[`CTRL_RX_EN] = rx_en;
    ctrl_word[`CTRL_TX_EN] = tx_en;
  end

  // Unmapped reads return zero
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= `RDATA_RESET;
    else if (i_rd && i_addr == `DMA_CTRL_OFFSET)
      o_rdata <= ctrl_word;
    else if (i_rd && i_addr == `DMA_MAXLEN_OFFSET)
      o_rdata <= {7'h00, max_len, 2'h0};
    else
      o_rdata <= `RDATA_RESET;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_TRUNC_CODE: assert property (
    o_wr_end && o_wr_trunc && trunc_code_en
    |=> o_dist_int_valid && o_dist_int_num == $past(irq_num))
    else $error("Truncation did not emit the interrupt code");

  AST_RX_IRQ_FLAG: assert property (
    rx_irq_ev |=> o_irq && rx_irq_flag)
    else $error("Receive interrupt without its flag");

  AST_TX_IRQ_FLAG: assert property (
    tx_irq_ev |=> o_irq && tx_irq_flag)
    else $error("Transmit interrupt without its flag");

  AST_NO_SPILL_STALL: assert property (
    (rx_state == dma_chan_pkg::RX_IDLE && no_spill && !desc_ok)[*2]
    |-> !o_rx_ready)
    else $error("Packet accepted with no descriptor under no-spill");

  AST_DESC_AVAIL_CLR: assert property (
    i_rx_desc_disabled && !(wr_ctrl && i_wdata[`CTRL_RX_DESC_AVAIL])
    |=> !rx_desc_avail)
    else $error("Descriptors-available not cleared");

  AST_RX_ACTIVE: assert property (
    i_rd && i_addr == `DMA_CTRL_OFFSET
    |=> o_rdata[`CTRL_RX_ACTIVE] == $past(rx_state == dma_chan_pkg::RX_RECV))
    else $error("Receive-active status wrong");

  AST_ABORT: assert property (
    abort_wr |=> !tx_en && o_tx_abort == $past(tx_busy) ##1 !o_tx_fetch)
    else $error("Abort did not stop the transmitter");

  AST_RX_BUS_ERR_GATE: assert property (
    i_rx_bus_err && !bus_err_irq_en && !rx_bus_err_flag |=> !rx_bus_err_flag)
    else $error("Receive bus error flag set while gated off");

  AST_TX_BUS_ERR: assert property (
    i_tx_bus_err |=> tx_bus_err_flag)
    else $error("Transmit bus error flag not set");

  AST_PKT_RX: assert property (
    o_wr_end |=> pkt_rx_flag)
    else $error("Packet-received flag not set");

  AST_PKT_TX: assert property (
    i_tx_done |=> pkt_tx_flag)
    else $error("Packet-sent flag not set");

  AST_ERR_IRQ: assert property (
    err_irq_ev |=> o_irq)
    else $error("Bus error raised no interrupt");

  AST_RX_ENABLE: assert property (
    o_rx_ready && rx_state == dma_chan_pkg::RX_IDLE |-> $past(rx_en))
    else $error("Ready while receiver disabled");

  AST_TX_FETCH: assert property (
    o_tx_fetch |-> $past(tx_en) && tx_busy)
    else $error("Fetch without transmitter enable");

  AST_W1C: assert property (
    wr_ctrl && i_wdata[`CTRL_PKT_TX] && !i_tx_done |=> !pkt_tx_flag)
    else $error("Write one did not clear packet-sent");

  COV_TRUNC: cover property (o_wr_end && o_wr_trunc ##1 o_dist_int_valid);
  COV_DISCARD: cover property (rx_state == dma_chan_pkg::RX_DISCARD);
  COV_ABORT: cover property (o_tx_abort);
  COV_RX_IRQ: cover property (rx_irq_ev ##1 o_irq);

endmodule

`default_nettype wire

// [sim/pkt_path_model.sv]
// Far side of the channel: packet path bytes and transmit engine answers.
// Assumes one clock shared with the channel under test.
`timescale 1ns/1ns
`default_nettype none
module pkt_path_model (
  input wire logic i_clk,
  input wire logic i_rx_ready,
  input wire logic i_tx_fetch,
  output logic o_rx_valid,
  output var dma_chan_pkg::rx_byte_type o_rx_byte,
  output logic o_tx_done,
  output logic o_tx_desc_disabled
);
  int tx_delay = 3;
  int sends_left = 0;
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_byte = '0;
    o_tx_done = 1'b0;
    o_tx_desc_disabled = 1'b0;
  end
  // Each byte held until taken
  task automatic send(input int n, input logic eep);
    for (int i = 0; i < n; i++)
    begin
      o_rx_valid <= 1'b1;
      o_rx_byte <= '{8'h10 + 8'(i), i == n - 1, eep && i == n - 1};
      do @(posedge i_clk); while (!i_rx_ready);
    end
    o_rx_valid <= 1'b0;
    // Released lines flip so stale data is never mistaken for a byte
    o_rx_byte <= ~o_rx_byte;
  endtask
  always @(posedge i_clk)
    if (i_tx_fetch)
    begin
      repeat (tx_delay) @(posedge i_clk);
      if (sends_left > 0)
      begin
        sends_left--;
        o_tx_done <= 1'b1;
      end
      else
        o_tx_desc_disabled <= 1'b1;
      @(posedge i_clk);
      o_tx_done <= 1'b0;
      o_tx_desc_disabled <= 1'b0;
    end
endmodule
`default_nettype wire

// [sim/dma_chan_ctrl_test.sv]
// Self-checking bench for the DMA channel control and status block.
// Assumes the far-side model supplies packet bytes and transmit answers.
`timescale 1ns/1ns
`default_nettype none
module dma_chan_ctrl_test;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 0;
  logic [31:0] i_wdata = 0, o_rdata;
  logic rx_valid, o_rx_ready, desc_act = 1, desc_dis = 0, desc_ie = 1;
  logic rx_err = 0, o_wr_valid, o_wr_end, o_wr_trunc, o_wr_eep;
  logic o_tx_fetch, o_tx_abort, tx_done, tx_dis, tx_ie = 1, tx_err = 0;
  logic o_irq, o_dist, o_sep;
  logic [5:0] o_num;
  logic [7:0] fb;
  dma_chan_pkg::rx_byte_type rx_byte, o_wr_byte;
  int fails = 0, cmp_count = 0, cyc = 0;
  int nwr, nirq, ndist, nfetch, nabort;
  dma_chan_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_rx_ready(o_rx_ready),
    .i_rx_desc_active(desc_act), .i_rx_desc_disabled(desc_dis),
    .i_rx_desc_irq_en(desc_ie), .i_rx_bus_err(rx_err),
    .o_wr_valid(o_wr_valid), .o_wr_byte(o_wr_byte), .o_wr_end(o_wr_end),
    .o_wr_trunc(o_wr_trunc), .o_wr_eep(o_wr_eep), .o_tx_fetch(o_tx_fetch),
    .o_tx_abort(o_tx_abort), .i_tx_done(tx_done),
    .i_tx_desc_disabled(tx_dis), .i_tx_desc_irq_en(tx_ie),
    .i_tx_bus_err(tx_err), .o_irq(o_irq), .o_dist_int_valid(o_dist),
    .o_dist_int_num(o_num), .o_sep_addr_en(o_sep));
  pkt_path_model m (.i_clk(i_clk), .i_rx_ready(o_rx_ready),
    .i_tx_fetch(o_tx_fetch), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
    .o_tx_done(tx_done), .o_tx_desc_disabled(tx_dis));
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  // Pulses stand a whole cycle, so counting off the edge avoids races
  always @(negedge i_clk)
  begin
    if (o_wr_valid && nwr == 0)
      fb = o_wr_byte.data;
    nwr += o_wr_valid;
    nirq += o_irq;
    ndist += o_dist;
    nfetch += o_tx_fetch;
    nabort += o_tx_abort;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      close_out();
    end
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task clr;
    nwr = 0;
    nirq = 0;
    ndist = 0;
    nfetch = 0;
    nabort = 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
    logic [31:0] d;
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
    @(posedge i_clk);
    chk($sformatf("reg %h", a), e, d & k);
  endtask
  task pulse_err(input logic t, input logic r);
    tx_err <= t;
    rx_err <= r;
    @(posedge i_clk);
    tx_err <= 1'b0;
    rx_err <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk(8'h24, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h24, 32'hFFFF_FFFF);
    rchk(8'h24, 32'hFFFF_FFFF, 32'h01FF_FFFC);
    wr(8'h30, 32'hFFFF_FFFF);
    rchk(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test registers done");
    wr(8'h20, 32'h1400_680A);
    clr();
    m.send(3, 1'b0);
    repeat (4) @(posedge i_clk);
    chk("bytes", 2, nwr);
    chk("first", 8'h11, fb);
    chk("irq", 1, nirq);
    chk("sep", 1, o_sep);
    rchk(8'h20, 32'h0008_0040, 32'h0008_0040);
    wr(8'h20, 32'h1408_884A);
    rchk(8'h20, 32'h0008_0040, 32'h0000_0000);
    desc_ie <= 1'b0;
    clr();
    m.send(4, 1'b0);
    repeat (4) @(posedge i_clk);
    chk("bytes", 2, nwr);
    chk("first", 8'h12, fb);
    chk("irq", 0, nirq);
    desc_ie <= 1'b1;
    $display("test strip done");
    wr(8'h24, 32'h0000_0004);
    @(posedge i_clk);
    wr(8'h20, 32'h1430_080A);
    clr();
    m.send(6, 1'b0);
    repeat (4) @(posedge i_clk);
    chk("bytes", 4, nwr);
    chk("dist", 1, ndist);
    chk("interrupt_number", 5, {26'h0, o_num});
    rchk(8'h20, 32'h0040_0000, 32'h0040_0000);
    clr();
    m.send(2, 1'b1);
    repeat (4) @(posedge i_clk);
    rchk(8'h20, 32'h0080_0000, 32'h0080_0000);
    chk("dist", 1, ndist);
    $display("test truncate done");
    desc_act <= 1'b0;
    wr(8'h20, 32'h1400_080A);
    clr();
    m.send(2, 1'b0);
    repeat (4) @(posedge i_clk);
    chk("bytes", 0, nwr);
    wr(8'h20, 32'h1400_180A);
    repeat (3) @(posedge i_clk);
    chk("ready", 0, o_rx_ready);
    desc_act <= 1'b1;
    wr(8'h20, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    chk("ready", 0, o_rx_ready);
    wr(8'h20, 32'h0000_0800);
    desc_dis <= 1'b1;
    @(posedge i_clk);
    desc_dis <= 1'b0;
    repeat (2) @(posedge i_clk);
    rchk(8'h20, 32'h0000_0800, 32'h0000_0000);
    $display("test descriptors done");
    m.sends_left = 1;
    clr();
    wr(8'h20, 32'h0000_0005);
    repeat (20) @(posedge i_clk);
    chk("fetch", 2, nfetch);
    chk("irq", 1, nirq);
    rchk(8'h20, 32'h0004_0021, 32'h0004_0020);
    m.sends_left = 1;
    m.tx_delay = 20;
    clr();
    wr(8'h20, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    wr(8'h20, 32'h0000_0200);
    repeat (2) @(posedge i_clk);
    chk("abort", 1, nabort);
    rchk(8'h20, 32'h0000_0201, 32'h0000_0000);
    repeat (25) @(posedge i_clk);
    chk("fetch", 1, nfetch);
    $display("test transmit done");
    wr(8'h20, 32'h0000_01A0);
    pulse_err(1'b1, 1'b1);
    rchk(8'h20, 32'h0000_0180, 32'h0000_0080);
    wr(8'h20, 32'h0000_0190);
    clr();
    pulse_err(1'b0, 1'b1);
    chk("irq", 1, nirq);
    rchk(8'h20, 32'h0000_0100, 32'h0000_0100);
    $display("test bus errors done");
    close_out();
  end
endmodule
`default_nettype wire
